// ==== src/status_pin_source_select.sv ====
/*
 * Configuration register and source multiplexer for the second status pin.
 * Assumes indicator inputs come from other clock domains or pins and are
 * synchronised here; register port is driven on this clock.
 */
// The address-and-strobe port was left to the implementer.
// Contract
// RULE1: A 4-bit read-write select field at bits [7:4] resets to 0x2 and picks the pin source.
// RULE2: Codes 0x0 and 0x1 drive primary and secondary reference signal loss.
// RULE3: Codes 0x2 and 0x5 drive first and second synthesizer lock loss.
// RULE4: Codes 0x3 and 0x6 drive the halved reference divider output, valid when not bypassed.
// RULE5: Codes 0x4 and 0x7 drive the halved feedback divider output of each synthesizer.
// RULE6: Codes 0xB and 0xC drive the halved pre-divider output, valid when not bypassed.
// RULE7: Codes 0x8 and 0x9 show VCO calibration in progress for each synthesizer.
// RULE8: Codes 0xE and 0xF show the secondary-to-primary switch event of each synthesizer.
// RULE9: Code 0xA drives the interrupt summary derived from the interrupt flags.
// RULE10: Code 0xD asserts the pin while the nonvolatile memory is busy.
// RULE11: A read-write polarity bit at [3] resets to 1; 1 is active high, 0 active low.
// RULE12: Active test configuration overrides select and polarity and drives test signals.
// RULE13: Bits [2:0] read as zero, ignore writes, and defaults load from nonvolatile storage.
`timescale 1ns/10ps
`include "pin_select_defs.svh"

module status_pin_source_select
	import pin_select_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       reset,
	input  wire logic [7:0] address,
	input  wire logic [7:0] write_data,
	input  wire logic       write_strobe,
	input  wire logic       read_strobe,
	output logic      [7:0] read_data,
	input  wire logic       primary_signal_loss,
	input  wire logic       secondary_signal_loss,
	input  wire logic       first_lock_loss,
	input  wire logic       second_lock_loss,
	input  wire logic       first_ref_div,
	input  wire logic       second_ref_div,
	input  wire logic       first_fb_div,
	input  wire logic       second_fb_div,
	input  wire logic       first_pre_div,
	input  wire logic       second_pre_div,
	input  wire logic       first_cal_active,
	input  wire logic       second_cal_active,
	input  wire logic       interrupt_summary,
	input  wire logic       nvm_busy,
	input  wire logic       first_switch_back,
	input  wire logic       second_switch_back,
	input  wire logic       test_active,
	input  wire logic       test_signal,
	input  wire logic       nvm_load,
	input  wire logic [7:0] nvm_defaults,
	output logic            second_indicator_pin,
	output logic            irq
);

	// ======================================================================
	// Input synchronisers
	localparam int N_IN = 19;

	logic [N_IN-1:0] raw_in;
	logic [N_IN-1:0] meta_q;
	logic [N_IN-1:0] sync_q;

	assign raw_in = {nvm_load, test_signal, test_active, second_switch_back,
		first_switch_back, nvm_busy, interrupt_summary, second_cal_active,
		first_cal_active, second_pre_div, first_pre_div, second_fb_div,
		first_fb_div, second_ref_div, first_ref_div, second_lock_loss,
		first_lock_loss, secondary_signal_loss, primary_signal_loss};

	// Two flip-flops per asynchronous input; only sync_q is read by logic.
	always_ff @(posedge clock) begin
		if (reset) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= raw_in;
			sync_q <= meta_q;
		end
	end

	logic s_test_act;
	logic s_test_sig;
	logic s_load;

	assign s_test_sig = sync_q[17];
	assign s_test_act = sync_q[16];
	assign s_load     = sync_q[18];

	// ======================================================================
	// Divider halving stages
	logic [5:0] div_in;
	logic [5:0] div_prev_q;
	logic [5:0] half_q;

	assign div_in = sync_q[9:4];

	// Each divider output toggles its half stage on every rising edge.
	always_ff @(posedge clock) begin
		if (reset) begin
			div_prev_q <= '0;
			half_q     <= '0;
		end else begin
			div_prev_q <= div_in;
			half_q     <= half_q ^ (div_in & ~div_prev_q); // [RULE4] [RULE5] [RULE6]
		end
	end

	// ======================================================================
	// Configuration register
	code_t sel_q;
	logic  pol_q;
	logic  load_prev_q;

	// Software writes and nonvolatile default loads; reserved bits dropped.
	always_ff @(posedge clock) begin
		if (reset) begin
			sel_q       <= `SEL_RESET; // [RULE1]
			pol_q       <= `POL_RESET; // [RULE11]
			load_prev_q <= 1'b0;
		end else begin
			load_prev_q <= s_load;
			if (s_load && !load_prev_q) begin
				sel_q <= nvm_defaults[`SEL_HI:`SEL_LO]; // [RULE13]
				pol_q <= nvm_defaults[`POL_BIT];        // [RULE13]
			end else if (write_strobe && address == `CFG_OFFSET) begin
				sel_q <= write_data[`SEL_HI:`SEL_LO]; // [RULE1]
				pol_q <= write_data[`POL_BIT];        // [RULE11]
			end
		end
	end

	// ======================================================================
	// Source multiplexer
	function automatic logic pick(input code_t code, input logic [N_IN-1:0] s,
		input logic [5:0] h);
		case (code)
			`CODE_PRI_LOS:   pick = s[0];  // [RULE2]
			`CODE_SEC_LOS:   pick = s[1];  // [RULE2]
			`CODE_S1_LOL:    pick = s[2];  // [RULE3]
			`CODE_S2_LOL:    pick = s[3];  // [RULE3]
			`CODE_S1_RDIV:   pick = h[0];  // [RULE4]
			`CODE_S2_RDIV:   pick = h[1];  // [RULE4]
			`CODE_S1_NDIV:   pick = h[2];  // [RULE5]
			`CODE_S2_NDIV:   pick = h[3];  // [RULE5]
			`CODE_S1_MDIV:   pick = h[4];  // [RULE6]
			`CODE_S2_MDIV:   pick = h[5];  // [RULE6]
			`CODE_S1_CAL:    pick = s[10]; // [RULE7]
			`CODE_S2_CAL:    pick = s[11]; // [RULE7]
			`CODE_INTERRUPT_SUMMARY:      pick = s[12]; // [RULE9]
			`CODE_NVM:       pick = s[13]; // [RULE10]
			`CODE_S1_SWITCH: pick = s[14]; // [RULE8]
			`CODE_S2_SWITCH: pick = s[15]; // [RULE8]
			default:         pick = 1'b0;
		endcase
	endfunction : pick

	logic chosen;

	assign chosen = pick(sel_q, sync_q, half_q);

	// Pin register: test mode wins, else selected source with polarity.
	always_ff @(posedge clock) begin
		if (reset) begin
			second_indicator_pin <= ~`POL_RESET;
		end else if (s_test_act) begin
			second_indicator_pin <= s_test_sig;        // [RULE12]
		end else begin
			second_indicator_pin <= chosen ^ ~pol_q;  // [RULE11]
		end
	end

	// ======================================================================
	// Event status, mask and interrupt
	logic [`EVT_WIDTH-1:0] evt_q;
	logic [`EVT_WIDTH-1:0] mask_q;
	logic [`EVT_WIDTH-1:0] evt_src;
	logic [`EVT_WIDTH-1:0] evt_prev_q;
	logic [`EVT_WIDTH-1:0] evt_rise;

	assign evt_src  = {sync_q[14], sync_q[13], sync_q[3], sync_q[2]};
	assign evt_rise = evt_src & ~evt_prev_q;

	// Sticky bits: a read clears, but a new event in the same cycle wins.
	always_ff @(posedge clock) begin
		if (reset) begin
			evt_prev_q <= '0;
			evt_q      <= '0;
		end else begin
			evt_prev_q <= evt_src;
			if (read_strobe && address == `EVT_OFFSET) begin
				evt_q <= evt_rise;
			end else begin
				evt_q <= evt_q | evt_rise;
			end
		end
	end

	// Mask register write.
	always_ff @(posedge clock) begin
		if (reset) begin
			mask_q <= '0;
		end else if (write_strobe && address == `MASK_OFFSET) begin
			mask_q <= write_data[`EVT_WIDTH-1:0];
		end
	end

	// Level interrupt from unmasked sticky bits.
	always_ff @(posedge clock) begin
		if (reset) begin
			irq <= 1'b0;
		end else begin
			irq <= |((evt_q | evt_rise) & mask_q);
		end
	end

	// ======================================================================
	// Read data, valid the cycle after the read strobe; unmapped reads zero.
	always_ff @(posedge clock) begin
		if (reset) begin
			read_data <= '0;
		end else if (read_strobe) begin
			case (address)
				`CFG_OFFSET:  read_data <= {sel_q, pol_q, 3'h0}; // [RULE13]
				`EVT_OFFSET:  read_data <= {4'h0, evt_q};
				`MASK_OFFSET: read_data <= {4'h0, mask_q};
				`TEST_OFFSET: read_data <= {6'h00, s_test_sig, s_test_act};
				default:      read_data <= '0;
			endcase
		end else begin
			read_data <= '0;
		end
	end

	// ======================================================================
	// Checks
	chk_sel_reset: assert property (@(posedge clock) $fell(reset) |-> sel_q == `SEL_RESET) // [RULE1]
		else $error("select field not at reset value");
	chk_sel_write: assert property (@(posedge clock) disable iff (reset) // [RULE1]
		(write_strobe && address == `CFG_OFFSET && !(s_load && !load_prev_q))
		|=> sel_q == $past(write_data[7:4]))
		else $error("select write not taken");
	chk_pol_write: assert property (@(posedge clock) disable iff (reset) // [RULE11]
		(write_strobe && address == `CFG_OFFSET && !(s_load && !load_prev_q))
		|=> pol_q == $past(write_data[3]))
		else $error("polarity write not taken");
	chk_reserved_zero: assert property (@(posedge clock) disable iff (reset) // [RULE13]
		(read_strobe && address == `CFG_OFFSET) |=> read_data[2:0] == 3'h0)
		else $error("reserved bits not zero");
	chk_test_wins: assert property (@(posedge clock) disable iff (reset) // [RULE12]
		s_test_act |=> second_indicator_pin == $past(s_test_sig))
		else $error("test override lost");
	chk_pri_los: assert property (@(posedge clock) disable iff (reset) // [RULE2]
		(!s_test_act && sel_q == `CODE_PRI_LOS && pol_q)
		|=> second_indicator_pin == $past(sync_q[0]))
		else $error("primary loss not routed");
	chk_lock_low: assert property (@(posedge clock) disable iff (reset) // [RULE3]
		(!s_test_act && sel_q == `CODE_S1_LOL && !pol_q)
		|=> second_indicator_pin == !$past(sync_q[2]))
		else $error("active low lock loss wrong");
	chk_nvm_busy: assert property (@(posedge clock) disable iff (reset) // [RULE10]
		(!s_test_act && sel_q == `CODE_NVM && pol_q && sync_q[13])
		|=> second_indicator_pin)
		else $error("memory busy not shown");
	chk_interrupt_summary_route: assert property (@(posedge clock) disable iff (reset) // [RULE9]
		(!s_test_act && sel_q == `CODE_INTERRUPT_SUMMARY && pol_q)
		|=> second_indicator_pin == $past(sync_q[12]))
		else $error("interrupt summary not routed");
	chk_half_toggle: assert property (@(posedge clock) disable iff (reset) // [RULE5]
		(div_in[2] && !div_prev_q[2]) |=> half_q[2] != $past(half_q[2]))
		else $error("feedback half stage did not toggle");

	cov_test_mode: cover property (@(posedge clock) disable iff (reset) s_test_act);
	cov_interrupt_summary_raise: cover property (@(posedge clock) disable iff (reset) $rose(irq));
	cov_cfg_write: cover property (@(posedge clock) disable iff (reset)
		write_strobe && address == `CFG_OFFSET);
	cov_half_pin: cover property (@(posedge clock) disable iff (reset)
		sel_q == `CODE_S1_RDIV && $changed(second_indicator_pin));
	cov_nvm_load: cover property (@(posedge clock) disable iff (reset) s_load && !load_prev_q);

	// Routing for either polarity, default loading, sticky status and bus idle.
	chk_cal_route: assert property (@(posedge clock) disable iff (reset) // [RULE7]
		(!s_test_act && sel_q == `CODE_S1_CAL)
		|=> second_indicator_pin == ($past(pol_q) ? $past(sync_q[10]) : !$past(sync_q[10])))
		else $error("calibration activity not routed");
	chk_switch_route: assert property (@(posedge clock) disable iff (reset) // [RULE8]
		(!s_test_act && sel_q == `CODE_S2_SWITCH)
		|=> second_indicator_pin == ($past(pol_q) ? $past(sync_q[15]) : !$past(sync_q[15])))
		else $error("switch event not routed");
	chk_load_defaults: assert property (@(posedge clock) disable iff (reset) // [RULE13]
		(s_load && !load_prev_q)
		|=> sel_q == $past(nvm_defaults[7:4]) && pol_q == $past(nvm_defaults[3]))
		else $error("stored defaults not loaded");
	chk_evt_sticky: assert property (@(posedge clock) disable iff (reset)
		(evt_rise != '0) |=> (evt_q & $past(evt_rise)) == $past(evt_rise))
		else $error("event lost from status");
	chk_irq_level: assert property (@(posedge clock) disable iff (reset)
		(|(evt_q & mask_q)) |=> irq)
		else $error("unmasked event did not interrupt");
	chk_read_idle: assert property (@(posedge clock) disable iff (reset)
		!read_strobe |=> read_data == 8'h00)
		else $error("read data outside its cycle");

endmodule : status_pin_source_select

// ==== src/pin_select_defs.svh ====
/*
 * Offsets, field positions, reset values and select codes for the second
 * status pin source selector.
 * Assumes inclusion by bare name; holds definitions only.
 */
`ifndef PIN_SELECT_DEFS_SVH
`define PIN_SELECT_DEFS_SVH

// ==========================================================================
// Register offsets
`define CFG_OFFSET      8'h1c
`define EVT_OFFSET      8'h40
`define MASK_OFFSET     8'h41
`define TEST_OFFSET     8'h42

// ==========================================================================
// Field positions and reset values
`define SEL_HI          7
`define SEL_LO          4
`define POL_BIT         3
`define SEL_RESET       4'h2
`define POL_RESET       1'b1
`define EVT_WIDTH       4

// ==========================================================================
// Select codes
`define CODE_PRI_LOS    4'h0
`define CODE_SEC_LOS    4'h1
`define CODE_S1_LOL     4'h2
`define CODE_S1_RDIV    4'h3
`define CODE_S1_NDIV    4'h4
`define CODE_S2_LOL     4'h5
`define CODE_S2_RDIV    4'h6
`define CODE_S2_NDIV    4'h7
`define CODE_S1_CAL     4'h8
`define CODE_S2_CAL     4'h9
`define CODE_INTERRUPT_SUMMARY       4'ha
`define CODE_S1_MDIV    4'hb
`define CODE_S2_MDIV    4'hc
`define CODE_NVM        4'hd
`define CODE_S1_SWITCH  4'he
`define CODE_S2_SWITCH  4'hf

`endif

// ==== src/pin_select_pkg.sv ====
/*
 * Types shared by the second status pin source selector.
 * Assumes nothing of its surroundings.
 */
package pin_select_pkg;
	typedef logic [3:0] code_t;
endpackage : pin_select_pkg

// ==== tb/pin_monitor.sv ====
/*
 * Board-side monitor of the second status pin: counts its transitions.
 * Assumes the pin is sampled on the block's own clock.
 */
`timescale 1ns/10ps

// ==========================================================================
// Pin edge counter
module pin_monitor (
	input  wire logic clock,
	input  wire logic pin,
	output int        edges
);
	logic last_q;

	// Counts every change seen on the pin, rising and falling alike, so one full pin period counts twice.
	initial edges = 0;
	always @(posedge clock) begin
		last_q <= pin;
		if (pin !== last_q) edges <= edges + 1;
	end
endmodule : pin_monitor

// ==== tb/tb_status_pin_source_select.sv ====
/*
 * Self-checking bench for the second status pin source selector.
 * Assumes the design files and the pin monitor are compiled first.
 */
`timescale 1ns/10ps
`include "pin_select_defs.svh"

// ==========================================================================
// Bench top
module tb_status_pin_source_select;
	import pin_select_pkg::*;
	logic        clock = 0, reset = 1, write_strobe = 0, read_strobe = 0;
	logic        test_active = 0, test_signal = 0, nvm_load = 0;
	logic [7:0]  address = 0, write_data = 0, nvm_defaults = 0, read_data;
	logic [15:0] src = 0;  // Indicator inputs, indexed by select code.
	logic        second_indicator_pin, irq, pol;
	int          mismatches = 0, checks_done = 0, cycles = 0, seed = 32'h6a8e, edges, e0;

	status_pin_source_select dut (.clock(clock), .reset(reset), .address(address),
		.write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
		.read_data(read_data), .primary_signal_loss(src[0]), .secondary_signal_loss(src[1]),
		.first_lock_loss(src[2]), .first_ref_div(src[3]), .first_fb_div(src[4]),
		.second_lock_loss(src[5]), .second_ref_div(src[6]), .second_fb_div(src[7]),
		.first_cal_active(src[8]), .second_cal_active(src[9]), .interrupt_summary(src[10]),
		.first_pre_div(src[11]), .second_pre_div(src[12]), .nvm_busy(src[13]),
		.first_switch_back(src[14]), .second_switch_back(src[15]),
		.test_active(test_active), .test_signal(test_signal), .nvm_load(nvm_load),
		.nvm_defaults(nvm_defaults), .second_indicator_pin(second_indicator_pin), .irq(irq));
	pin_monitor monitor (.clock(clock), .pin(second_indicator_pin), .edges(edges));

	// Free-running clock and a hang guard.
	initial forever #2 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 6000) begin
			mismatches++;
			end_of_test();
		end
	end

	// Expected pin level: the selected source, inverted when active low.
	function automatic logic pin_exp(input logic [3:0] c, input logic p);
		return src[c] ^ ~p;
	endfunction : pin_exp

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		address <= a;
		write_data <= d;
		write_strobe <= 1;
		@(posedge clock);
		write_strobe <= 0;
	endtask : wr

	// Read data stand only in the cycle after the strobe.
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input bit chk);
		@(posedge clock);
		address <= a;
		read_strobe <= 1;
		@(posedge clock);
		read_strobe <= 0;
		#1;
		if (chk) check(read_data, exp);
	endtask : rd

	task automatic settle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : settle

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : end_of_test

	// Main sequence.
	initial begin
		repeat (5) @(posedge clock);
		reset <= 0;
		rd(`CFG_OFFSET, 8'h28, 1);
		rd(8'h00, 8'h00, 1);
		wr(`MASK_OFFSET, 8'h00);
		for (int c = 0; c < 16; c++) begin
			pol = 1'($random(seed));
			wr(`CFG_OFFSET, {c[3:0], pol, 3'h7});
			rd(`CFG_OFFSET, {c[3:0], pol, 3'h0}, 1);
			if (16'h18d8 >> c & 1) begin
				settle(6);
				e0 = edges;
				repeat (4) begin
					@(posedge clock) src[c] <= 1;
					repeat (8) @(posedge clock);
					src[c] <= 0;
					repeat (8) @(posedge clock);
				end
				settle(6);
				check(8'(edges - e0), 8'h04);
			end else repeat (3) begin
				@(posedge clock) src <= 16'($random(seed)) & ~16'h18d8;
				settle(5);
				check(second_indicator_pin, pin_exp(c[3:0], pol));
			end
		end
		// Sticky events: an unmasked bit raises the interrupt and a status read clears it.
		@(posedge clock) src <= 0;
		settle(5);
		rd(`EVT_OFFSET, 8'h00, 0);
		wr(`MASK_OFFSET, 8'h01);
		rd(`MASK_OFFSET, 8'h01, 1);
		@(posedge clock) src <= 16'h2004;
		settle(5);
		check(irq, 1'b1);
		rd(`EVT_OFFSET, 8'h05, 1);
		settle(2);
		check(irq, 1'b0);
		rd(`EVT_OFFSET, 8'h00, 1);
		// Test override beats select, with polarity set active high.
		wr(`CFG_OFFSET, 8'h28);
		@(posedge clock) test_active <= 1;
		repeat (4) begin
			@(posedge clock) test_signal <= 1'($random(seed));
			settle(5);
			check(second_indicator_pin, test_signal);
			rd(`TEST_OFFSET, {6'h00, test_signal, 1'b1}, 1);
		end
		@(posedge clock) test_active <= 0;
		// Defaults load from storage.
		@(posedge clock) nvm_defaults <= 8'h5f;
		nvm_load <= 1;
		repeat (5) @(posedge clock);
		nvm_load <= 0;
		rd(`CFG_OFFSET, 8'h58, 1);
		end_of_test();
	end
endmodule : tb_status_pin_source_select
